// file: include/dcap_pkg.sv
package dcap_pkg;
   // APB address width, config space sized
   localparam int ADDR_W = 12;
   localparam logic [11:0] DEV_CAP_OFFS = 12'h0B4;
   localparam logic [11:0] CTRL_OFFS = 12'h1F0;
   // Field positions within the capability word
   localparam int MPS_LSB = 0;
   localparam int PHANTOM_LSB = 3;
   localparam int EXT_TAG_BIT = 5;
   localparam int L0S_LSB = 6;
   localparam int L1_LSB = 9;
   localparam int BUTTON_BIT = 12;
   localparam int ATTN_IND_BIT = 13;
   localparam int PWR_IND_BIT = 14;
   localparam int RSV_LSB = 15;
   localparam int SPL_VAL_LSB = 18;
   localparam int SPL_SCALE_LSB = 26;
   // Reset and fixed values
   localparam logic [2:0] MPS_RST = 3'h2;
   localparam logic [1:0] PHANTOM_RST = 2'h0;
   localparam logic EXT_TAG_RST = 1'b1;
   localparam logic [2:0] L0S_RST = 3'h0;
   localparam logic [2:0] L1_RST = 3'h0;
   localparam logic [2:0] RSV_RST = 3'h1;
   localparam logic [3:0] TOP_RSV_RST = 4'h0;
   localparam logic [7:0] SPL_VAL_RST = 8'h00;
   localparam logic [1:0] SPL_SCALE_RST = 2'h0;
   localparam logic CTRL_EN_RST = 1'b1;
   // Edges after reset before the strap is trusted
   localparam logic [1:0] STRAP_STAGES = 2'h2;
endpackage

// file: include/dcap_msg_if.sv
`timescale 1ns/1ps
interface dcap_msg_if;
   logic valid;
   logic [7:0] value;
   logic [1:0] scale;
   logic enable;
   logic [7:0] cap_value;
   logic [1:0] cap_scale;
   modport producer (output valid, value, scale, enable,
                     input cap_value, cap_scale);
   modport capture (input valid, value, scale, enable,
                    output cap_value, cap_scale);
endinterface

// file: src/dcap_capture.sv
`timescale 1ns/1ps
module dcap_capture (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Power limit message path
   dcap_msg_if.capture msg
);
   typedef struct packed {
      logic [7:0] value;
      logic [1:0] scale;
   } dcap_cap_state_t;

   dcap_cap_state_t st;
   dcap_cap_state_t next_st;

   // Load both fields together from one message
   always_comb begin
      next_st = st;
      if (msg.valid && msg.enable) begin
         // (RULE7) value from payload
         next_st.value = msg.value;
         // (RULE8) scale from payload
         next_st.scale = msg.scale;
      end
   end

   // (RULE7) value cleared at reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st.value <= dcap_pkg::SPL_VAL_RST;
         st.scale <= dcap_pkg::SPL_SCALE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign msg.cap_value = st.value;
   assign msg.cap_scale = st.scale;

   sequence s_msg_taken;
      msg.valid && msg.enable;
   endsequence

   a_value_load: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
      s_msg_taken |=> msg.cap_value == $past(msg.value))
      else $error("power limit value not loaded");
   a_scale_load: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
      s_msg_taken |=> msg.cap_scale == $past(msg.scale))
      else $error("power limit scale not loaded");
   a_value_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
      !(msg.valid && msg.enable) |=> $stable(msg.cap_value)
         && $stable(msg.cap_scale))
      else $error("power limit changed without message");
endmodule

// file: src/dcap_top.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Phantom function field always reads 00, none supported.
// (RULE2) Extended tag bit always reads 1, eight-bit tags supported.
// (RULE3) L0s acceptable latency field reads 000, below 64 ns.
// (RULE4) L1 acceptable latency field reads 000, below 1 us.
// (RULE5) Attention button present follows hot-plug strap in forward mode.
// (RULE6) Attention and power indicator bits follow the same strap.
// (RULE7) Power limit value resets to zero, loads from each message; here only while ctrl_en is set.
// (RULE8) Power limit scale resets to zero, loads from each message; here only while ctrl_en is set.
// (RULE9) Writes to the capability word change nothing.
module dcap_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dcap_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Strap pins, asynchronous
   input wire logic hotplug_strap,
   input wire logic forward_strap,
   // Set_Slot_Power_Limit message from the link core
   input wire logic slot_msg_valid,
   input wire logic [7:0] slot_msg_value,
   input wire logic [1:0] slot_msg_scale
);
   typedef struct packed {
      logic hp_s1;
      logic hp_s2;
      logic fwd_s1;
      logic fwd_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic hp_en;
      logic fwd;
      logic ctrl_en;
      logic [31:0] rdata;
      logic err;
   } dcap_state_t;

   dcap_state_t st;
   dcap_state_t next_st;
   logic [31:0] cap_word;
   logic presence;
   logic setup;
   logic access;

   dcap_msg_if msg ();

   // Build the capability word from live state
   function automatic logic [31:0] dcap_word(
      input logic pres,
      input logic [7:0] val,
      input logic [1:0] scl
   );
      // (RULE1) phantom zero, (RULE2) tag one
      // (RULE3) L0s zero, (RULE4) L1 zero
      dcap_word = {dcap_pkg::TOP_RSV_RST, scl, val, dcap_pkg::RSV_RST,
                   pres, pres, pres, dcap_pkg::L1_RST, dcap_pkg::L0S_RST,
                   dcap_pkg::EXT_TAG_RST, dcap_pkg::PHANTOM_RST,
                   dcap_pkg::MPS_RST};
   endfunction

   // Address decode used by read and write paths
   function automatic logic [1:0] dcap_decode(
      input logic [dcap_pkg::ADDR_W-1:0] a
   );
      dcap_decode = {a == dcap_pkg::CTRL_OFFS, a == dcap_pkg::DEV_CAP_OFFS};
   endfunction

   // (RULE5) button present needs strap and forward
   // (RULE6) indicators share the same condition
   assign presence = st.hp_en && st.fwd;
   assign cap_word = dcap_word(presence, msg.cap_value, msg.cap_scale);
   assign setup = psel && !penable;
   assign access = psel && penable;

   // Message path into the capture register
   assign msg.valid = slot_msg_valid;
   assign msg.value = slot_msg_value;
   assign msg.scale = slot_msg_scale;
   assign msg.enable = st.ctrl_en;

   dcap_capture u_capture (
      .mclk(mclk),
      .rst_n(rst_n),
      .msg(msg)
   );

   // Next state: strap capture and APB
   always_comb begin
      logic [1:0] dec;
      dec = dcap_decode(paddr);
      next_st = st;
      // Two flops before anything looks at the pins
      next_st.hp_s1 = hotplug_strap;
      next_st.hp_s2 = st.hp_s1;
      next_st.fwd_s1 = forward_strap;
      next_st.fwd_s2 = st.fwd_s1;
      // Strap is caught once, after the synchroniser fills
      if (!st.strap_done) begin
         if (st.strap_cnt == dcap_pkg::STRAP_STAGES) begin
            next_st.hp_en = st.hp_s2;
            next_st.fwd = st.fwd_s2;
            next_st.strap_done = 1'b1;
         end else begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
         end
      end
      // Read data latched in setup so it leaves a flop
      if (setup) begin
         next_st.rdata = 32'h0000_0000;
         next_st.err = !(|dec);
         if (!pwrite && dec[0]) begin
            next_st.rdata = cap_word;
         end else if (!pwrite && dec[1]) begin
            next_st.rdata = {31'h0000_0000, st.ctrl_en};
         end
      end
      // (RULE9) only the control word takes writes
      if (access && pwrite && dec[1]) begin
         next_st.ctrl_en = pwdata[0];
      end
   end

   // State register, constants only under reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st.hp_s1 <= 1'b0;
         st.hp_s2 <= 1'b0;
         st.fwd_s1 <= 1'b0;
         st.fwd_s2 <= 1'b0;
         st.strap_cnt <= 2'h0;
         st.strap_done <= 1'b0;
         st.hp_en <= 1'b0;
         st.fwd <= 1'b0;
         st.ctrl_en <= dcap_pkg::CTRL_EN_RST;
         st.rdata <= 32'h0000_0000;
         st.err <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // One wait-free access phase; data already registered
   assign pready = access;
   assign prdata = st.rdata;
   assign pslverr = st.err;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_cap_read;
      access && !pwrite && paddr == dcap_pkg::DEV_CAP_OFFS;
   endsequence

   sequence s_cap_write;
      access && pwrite && paddr == dcap_pkg::DEV_CAP_OFFS
         && !slot_msg_valid && st.strap_done;
   endsequence

   a_phantom_zero: assert property ( // RULE1
      s_cap_read |-> prdata[dcap_pkg::PHANTOM_LSB +: 2] == 2'h0)
      else $error("phantom field not zero");
   a_ext_tag_one: assert property ( // RULE2
      s_cap_read |-> prdata[dcap_pkg::EXT_TAG_BIT] == 1'b1)
      else $error("extended tag bit not set");
   a_l0s_zero: assert property ( // RULE3
      s_cap_read |-> prdata[dcap_pkg::L0S_LSB +: 3] == 3'h0)
      else $error("L0s latency not zero");
   a_l1_zero: assert property ( // RULE4
      s_cap_read |-> prdata[dcap_pkg::L1_LSB +: 3] == 3'h0)
      else $error("L1 latency not zero");
   a_button_strap: assert property ( // RULE5
      (s_cap_read and st.strap_done) |->
         prdata[dcap_pkg::BUTTON_BIT] == (st.hp_en && st.fwd))
      else $error("button bit disagrees with strap");
   a_indicator_strap: assert property ( // RULE6
      (s_cap_read and st.strap_done) |->
         prdata[dcap_pkg::ATTN_IND_BIT] == prdata[dcap_pkg::BUTTON_BIT]
         && prdata[dcap_pkg::PWR_IND_BIT] == (st.hp_en && st.fwd))
      else $error("indicator bits disagree with strap");
   // Both fields must be quiet since setup, else the latch saw older data
   a_limit_readback: assert property ( // RULE7 RULE8
      s_cap_read ##0 ($stable(msg.cap_value) && $stable(msg.cap_scale)) |->
         prdata[dcap_pkg::SPL_VAL_LSB +: 8] == msg.cap_value
         && prdata[dcap_pkg::SPL_SCALE_LSB +: 2] == msg.cap_scale)
      else $error("power limit readback wrong");
   a_ro_write: assert property ( // RULE9
      s_cap_write |=> $stable(cap_word) && !pslverr)
      else $error("write altered capability word");
endmodule

// file: test/dcap_link_model.sv
`timescale 1ns/1ps
// Link core side: one message pulse for each cycle of send
module dcap_link_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bench request
   input wire logic send,
   input wire logic [7:0] v,
   input wire logic [1:0] s,
   // Message toward the device
   output logic valid,
   output logic [7:0] value,
   output logic [1:0] scale
);
   // Idle payload toggles so stale data never looks valid
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         valid <= 1'b0;
         value <= 8'h00;
         scale <= 2'h0;
      end else begin
         valid <= send;
         value <= send ? v : ~value;
         scale <= send ? s : ~scale;
      end
   end
endmodule

// file: test/tb_dcap_top.sv
`timescale 1ns/1ps
module tb_dcap_top;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic hp, fw, send, mvalid;
   logic [dcap_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] mv, mval, ev;
   logic [1:0] ms, mscl, es;
   int error_cnt, checks, k;
   localparam logic [11:0] CAP = dcap_pkg::DEV_CAP_OFFS;
   localparam logic [11:0] CTL = dcap_pkg::CTRL_OFFS;

   dcap_top dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hotplug_strap(hp), .forward_strap(fw),
      .slot_msg_valid(mvalid), .slot_msg_value(mval),
      .slot_msg_scale(mscl));
   dcap_link_model link (.mclk(mclk), .rst_n(rst_n), .send(send),
      .v(mv), .s(ms), .valid(mvalid), .value(mval), .scale(mscl));

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Expected capability word
   function automatic logic [31:0] cap(input logic h, f,
      input logic [7:0] v, input logic [1:0] s);
      cap = {4'h0, s, v, 3'h1, {3{h & f}}, 3'h0, 3'h0, 1'b1, 2'h0, 3'h2};
   endfunction

   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic end_sim;
      $display("Counts: %0d checks, %0d errors", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Bus cycle; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 8) begin
         chk("pready", 32'h1, 32'h0);
         end_sim;
      end
   endtask

   // Straps must be stable after reset until caught on the third edge
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask

   task automatic put(input logic [7:0] v, input logic [1:0] s);
      @(posedge mclk);
      send <= 1'b1;
      mv <= v;
      ms <= s;
   endtask

   task automatic fin;
      @(posedge mclk);
      send <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, hp, fw, send} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      {mv, ms} = 10'h000;
      error_cnt = 0;
      checks = 0;
      k = $urandom(82313);
      // every strap pair, fields at reset
      for (k = 0; k < 4; k++) begin
         hp <= k[1];
         fw <= k[0];
         do_reset;
         apb(1'b0, CAP, 32'h0);
         chk("cap", cap(k[1], k[0], 8'h00, 2'h0), rd);
         chk("lat", 32'h0, 32'(rd[11:6]));
         chk("pres", 32'({3{k[1] & k[0]}}), 32'(rd[14:12]));
         chk("err", 32'h0, {31'h0, er});
      end
      $display("Test straps done");
      for (k = 0; k < 8; k++) begin
         ev = (k == 0) ? 8'hFF : 8'($urandom);
         es = (k == 0) ? 2'h3 : 2'($urandom);
         if (k[0]) put(8'($urandom), 2'($urandom));
         put(ev, es);
         fin;
         apb(1'b0, CAP, 32'h0);
         chk("msg", cap(1'b1, 1'b1, ev, es), rd);
      end
      $display("Test messages done");
      for (k = 0; k < 3; k++) begin
         apb(1'b1, CAP, (k == 0) ? 32'hFFFFFFFF : $urandom);
         chk("wr err", 32'h0, {31'h0, er});
         apb(1'b0, CAP, 32'h0);
         chk("wr", cap(1'b1, 1'b1, ev, es), rd);
      end
      $display("Test writes done");
      // Capture disabled, then unmapped access
      apb(1'b1, CTL, 32'h0);
      apb(1'b0, CTL, 32'h0);
      chk("ctl", 32'h0, rd);
      put(~ev, ~es);
      fin;
      apb(1'b0, CAP, 32'h0);
      chk("off", cap(1'b1, 1'b1, ev, es), rd);
      apb(1'b1, CTL, 32'h1);
      apb(1'b0, 12'h0B8, 32'h0);
      chk("unmap", 32'h1, {31'h0, er});
      chk("unmap rd", 32'h0, rd);
      $display("Test control done");
      end_sim;
   end
endmodule
